// *** dmc_pkg.sv ***
// Constants for the DMA channel mode control block: register map,
// field positions, reset values and channel states.
// Assumes a 32-bit classic Wishbone register bus and four channels.
package dmc_pkg;
   localparam int NCH = 4;
   localparam int CH_IDX_W = 2;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_MODE0 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_COUNT0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h28;

   // Mode control field positions
   localparam int BIT_XFER_EN = 31;
   localparam int BIT_ACK_DIS = 30;
   localparam int BIT_END_DIS = 29;
   localparam int BIT_RSVD_RW = 28;
   localparam int BIT_SENSE = 27;
   localparam int BIT_DELAY = 26;
   localparam int BIT_ACTIVE = 23;
   localparam int BIT_SYS_ERR = 19;
   localparam logic [31:0] RSVD_MASK = 32'h0374_0000;

   // Interrupt status bit of the system error; channel ends use bits 0..NCH-1
   localparam int IRQ_ERR_BIT = NCH;
   // Control register: dual address bits 0..NCH-1, module stop bit
   localparam int CTRL_STOP_BIT = NCH;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {CH_WAIT, CH_XFER, CH_GAP} dmc_chan_state_type;
endpackage : dmc_pkg

// *** dmc_req_sense.sv ***
// Request pin sensing for one channel: synchroniser, falling-edge
// catch and level/edge selection.
// Assumes the request pin is asynchronous and active low.
`timescale 1ns/1ps
module dmc_req_sense
   import dmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pin and mode
   input wire logic reqPinB,
   input wire logic edgeMode,
   input wire logic firstReq,
   // Handshake with the channel
   input wire logic take,
   output logic reqValid
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic pend;
   } dmc_sense_type;

   dmc_sense_type r;
   dmc_sense_type s;

   always_comb begin
      s = r;
      s.sync1 = reqPinB;
      s.sync2 = r.sync1;
      s.prev = r.sync2;
      // Level start after enabling serves its own edge; stale edges dropped
      if (take || firstReq) begin
         s.pend = 1'b0;
      end
      // Edge caught while taking still counts
      if (r.prev && !r.sync2 && !firstReq) begin
         s.pend = 1'b1;
      end
   end

   assign reqValid = edgeMode ? (r.pend || (firstReq && !r.sync2)) : !r.sync2;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, pend: 1'b0};
      end else begin
         r <= s;
      end
   end
endmodule : dmc_req_sense

// *** dmc_mode_ctrl.sv ***
// Upper mode control fields of four DMA channels with request sensing,
// acknowledge and end pins, system error lock and an interrupt.
// Assumes a classic Wishbone master on clk and error events as
// one-cycle pulses on the same clock.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module dmc_mode_ctrl
   import dmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // System events
   input wire logic addrErr,
   input wire logic nmiReq,
   // Peripheral pins, active low; output enables active high
   input wire logic [NCH-1:0] transferRequestPinB,
   output logic [NCH-1:0] transferAckPinB,
   output logic [NCH-1:0] transferAckPinOe,
   output logic [NCH-1:0] transferEndPinB,
   output logic [NCH-1:0] transferEndPinOe,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      logic [NCH-1:0] xferEn;
      logic [NCH-1:0] ackOutDis;
      logic [NCH-1:0] endOutDis;
      logic [NCH-1:0] rsvdBit;
      logic [NCH-1:0] senseEdge;
      logic [NCH-1:0] reqDelay;
      logic [NCH-1:0] firstReq;
      logic [NCH-1:0] dualAddr;
      logic [NCH-1:0][CNT_W-1:0] count;
      dmc_chan_state_type [NCH-1:0] state;
      logic sysErr;
      logic sysErrRead;
      logic moduleStop;
      logic [NCH:0] irqStat;
      logic [NCH:0] irqMask;
      logic [NCH-1:0] ackB;
      logic [NCH-1:0] ackOe;
      logic [NCH-1:0] endB;
      logic [NCH-1:0] endOe;
      logic wbAck;
      logic [31:0] wbDat;
      logic irq;
   } dmc_state_type;

   dmc_state_type r;
   dmc_state_type s;
   logic [NCH-1:0] reqOk;
   logic [NCH-1:0] take;
   logic wbReq;
   logic [CH_IDX_W-1:0] chIdx;

   function automatic logic isMode(input logic [ADDR_W-1:0] a);
      return a >= OFS_MODE0 && a < OFS_COUNT0 && a[1:0] == 2'h0;
   endfunction : isMode

   function automatic logic isCount(input logic [ADDR_W-1:0] a);
      return a >= OFS_COUNT0 && a < OFS_IRQ_STAT && a[1:0] == 2'h0;
   endfunction : isCount

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gSense
         dmc_req_sense uSense (
            .clk(clk),
            .rst_b(rst_b),
            .reqPinB(transferRequestPinB[g]),
            .edgeMode(r.senseEdge[g]),
            .firstReq(r.firstReq[g]),
            .take(take[g]),
            .reqValid(reqOk[g])
         );
      end
   endgenerate

   assign wbReq = wb_cyc_i && wb_stb_i && !r.wbAck;
   assign chIdx = wb_adr_i[IDX_LSB +: CH_IDX_W];

   always_comb begin
      s = r;
      take = '0;
      s.wbAck = 1'b0;
      s.ackB = '1;
      s.endB = '1;
      // Register bus, one wait state
      if (wbReq) begin
         s.wbAck = 1'b1;
         s.wbDat = RST_WORD;
         if (isMode(wb_adr_i)) begin
            s.wbDat[BIT_XFER_EN] = r.xferEn[chIdx];
            s.wbDat[BIT_ACK_DIS] = r.ackOutDis[chIdx];
            s.wbDat[BIT_END_DIS] = r.endOutDis[chIdx];
            s.wbDat[BIT_RSVD_RW] = r.rsvdBit[chIdx];
            s.wbDat[BIT_SENSE] = r.senseEdge[chIdx];
            s.wbDat[BIT_DELAY] = r.reqDelay[chIdx];
            s.wbDat[BIT_ACTIVE] = r.state[chIdx] == CH_XFER;
            if (chIdx == '0) begin
               s.wbDat[BIT_SYS_ERR] = r.sysErr;
               if (!wb_we_i && r.sysErr) begin
                  s.sysErrRead = 1'b1;
               end
            end
         end else if (isCount(wb_adr_i)) begin
            s.wbDat[CNT_W-1:0] = r.count[chIdx];
         end else if (wb_adr_i == OFS_IRQ_STAT) begin
            s.wbDat[NCH:0] = r.irqStat;
         end else if (wb_adr_i == OFS_IRQ_MASK) begin
            s.wbDat[NCH:0] = r.irqMask;
         end else if (wb_adr_i == OFS_CTRL) begin
            s.wbDat[NCH-1:0] = r.dualAddr;
            s.wbDat[CTRL_STOP_BIT] = r.moduleStop;
         end
         if (wb_we_i) begin
            if (isMode(wb_adr_i) && wb_sel_i[3]) begin
               if (!r.sysErr) begin
                  s.xferEn[chIdx] = wb_dat_i[BIT_XFER_EN];
                  if (wb_dat_i[BIT_XFER_EN] && !r.xferEn[chIdx]) begin
                     s.firstReq[chIdx] = 1'b1;
                  end
               end
               s.ackOutDis[chIdx] = wb_dat_i[BIT_ACK_DIS];
               s.endOutDis[chIdx] = wb_dat_i[BIT_END_DIS];
               s.rsvdBit[chIdx] = wb_dat_i[BIT_RSVD_RW];
               s.senseEdge[chIdx] = wb_dat_i[BIT_SENSE];
               s.reqDelay[chIdx] = wb_dat_i[BIT_DELAY];
            end
            if (isMode(wb_adr_i) && chIdx == '0 && wb_sel_i[2] && r.sysErrRead
                && !wb_dat_i[BIT_SYS_ERR]) begin
               s.sysErr = 1'b0;
               s.sysErrRead = 1'b0;
            end
            if (isCount(wb_adr_i)) begin
               for (int b = 0; b < CNT_W / 8; b++) begin
                  if (wb_sel_i[b]) begin
                     s.count[chIdx][8*b +: 8] = wb_dat_i[8*b +: 8];
                  end
               end
            end else if (wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0]) begin
               s.irqStat = r.irqStat & ~wb_dat_i[NCH:0];
            end else if (wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0]) begin
               s.irqMask = wb_dat_i[NCH:0];
            end else if (wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
               s.dualAddr = wb_dat_i[NCH-1:0];
               s.moduleStop = wb_dat_i[CTRL_STOP_BIT];
            end
         end
      end
      // Channel sequencers; hardware updates win over the bus
      for (int c = 0; c < NCH; c++) begin
         case (r.state[c])
            CH_WAIT: begin
               if (r.xferEn[c] && reqOk[c]) begin
                  take[c] = 1'b1;
                  s.firstReq[c] = 1'b0;
                  s.state[c] = CH_XFER;
                  s.ackB[c] = r.dualAddr[c] || r.ackOutDis[c];
                  s.endB[c] = !(r.count[c] == CNT_ONE && !r.endOutDis[c]);
               end
            end
            CH_XFER: begin
               s.count[c] = r.count[c] - CNT_ONE;
               if (r.count[c] == CNT_ONE) begin
                  s.xferEn[c] = 1'b0;
                  s.irqStat[c] = 1'b1;
               end
               s.state[c] = r.reqDelay[c] ? CH_GAP : CH_WAIT;
            end
            default: begin
               s.state[c] = CH_WAIT;
            end
         endcase
      end
      if (addrErr || nmiReq) begin
         s.xferEn = '0;
         if (!r.moduleStop) begin
            s.sysErr = 1'b1;
            s.irqStat[IRQ_ERR_BIT] = 1'b1;
         end
      end
      s.endOe = ~s.endOutDis;
      s.ackOe = ~(s.dualAddr | s.ackOutDis);
      s.irq = |(s.irqStat & s.irqMask);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.ackB <= '1;
         r.endB <= '1;
         r.ackOe <= '1;
         r.endOe <= '1;
      end else begin
         r <= s;
      end
   end

   assign wb_dat_o = r.wbDat;
   assign wb_ack_o = r.wbAck;
   assign transferAckPinB = r.ackB;
   assign transferAckPinOe = r.ackOe;
   assign transferEndPinB = r.endB;
   assign transferEndPinOe = r.endOe;
   assign irq = r.irq;

   default clocking dmcClk @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_err_set_flag: assert property (
      (addrErr || nmiReq) && !r.moduleStop |=> r.sysErr && r.irqStat[IRQ_ERR_BIT])
      else $error("system error flag not set by event");

   a_stop_keeps_zero: assert property (
      !r.sysErr && r.moduleStop && (addrErr || nmiReq) |=> !r.sysErr)
      else $error("system error flag set in module stop");

   a_err_clears_enable: assert property (
      (addrErr || nmiReq) |=> r.xferEn == '0 ##1 r.state[0] != CH_XFER)
      else $error("transfer enable survived an error event");

   a_err_locks_enable: assert property (
      r.sysErr && wbReq && wb_we_i && isMode(wb_adr_i) && wb_sel_i[3]
      |=> (r.xferEn & ~$past(r.xferEn)) == '0)
      else $error("transfer enable written while system error set");

   a_err_needs_read: assert property (
      r.sysErr && !r.sysErrRead |=> r.sysErr)
      else $error("system error cleared without a prior read");

   a_ack_pin_drive: assert property (
      r.state[0] == CH_WAIT && r.xferEn[0] && reqOk[0] && !r.ackOutDis[0]
      && !r.dualAddr[0] && !wbReq && !addrErr && !nmiReq
      |=> !transferAckPinB[0] && transferAckPinOe[0] ##1 transferAckPinB[0])
      else $error("acknowledge pin not pulsed for a taken request");

   a_dual_no_ack: assert property (
      r.dualAddr[1] && !wbReq |=> !transferAckPinOe[1] && transferAckPinB[1])
      else $error("acknowledge pin driven in dual address mode");

   a_end_final_xfer: assert property (
      take[0] && r.count[0] == CNT_ONE && !r.endOutDis[0] && !wbReq
      |=> !transferEndPinB[0] && transferEndPinOe[0] ##1 !r.xferEn[0])
      else $error("end pin not low on final transfer");

   a_delay_gap: assert property (
      r.state[0] == CH_XFER && r.reqDelay[0] |=> r.state[0] == CH_GAP ##1 r.state[0] == CH_WAIT)
      else $error("next request delay cycle missing");

   a_reserved_zero: assert property (
      wb_ack_o |-> (wb_dat_o & RSVD_MASK) == RST_WORD)
      else $error("reserved bits read as nonzero");

   a_active_status: assert property (
      wbReq && !wb_we_i && wb_adr_i == OFS_MODE0
      |=> wb_dat_o[BIT_ACTIVE] == ($past(r.state[0]) == CH_XFER))
      else $error("active status does not follow the channel state");

   a_first_take_once: assert property (
      take[0] && r.firstReq[0] && r.senseEdge[0] && !wbReq |=> !reqOk[0])
      else $error("edge mode took a second request from the first level");

   a_level_request: assert property (
      r.state[0] == CH_WAIT && r.xferEn[0] && !r.senseEdge[0]
      && !$past(transferRequestPinB[0], 2) |-> take[0])
      else $error("low request level not taken in level mode");

   a_ack_one_cycle: assert property (
      !transferAckPinB[0] |=> transferAckPinB[0])
      else $error("acknowledge pin low for more than one cycle");

   a_ack_gate_off: assert property (
      r.ackOutDis[3] && !wbReq |=> !transferAckPinOe[3] && transferAckPinB[3])
      else $error("acknowledge pin driven while its output is disabled");

   a_end_one_cycle: assert property (
      !transferEndPinB[1] |=> transferEndPinB[1])
      else $error("end pin low for more than one cycle");

   a_end_pin_gate: assert property (
      r.endOutDis[2] && !wbReq |=> !transferEndPinOe[2] && transferEndPinB[2])
      else $error("end pin driven while its output is disabled");

   a_chan_err_zero: assert property (
      wbReq && !wb_we_i && isMode(wb_adr_i) && wb_adr_i != OFS_MODE0
      |=> !wb_dat_o[BIT_SYS_ERR])
      else $error("system error bit seen outside channel 0");

   a_enable_write: assert property (
      !r.sysErr && wbReq && wb_we_i && wb_adr_i == OFS_MODE0 && wb_sel_i[3]
      && wb_dat_i[BIT_XFER_EN] && r.state[0] != CH_XFER && !addrErr && !nmiReq
      |=> r.xferEn[0])
      else $error("transfer enable write did not take effect");

   a_delay_none: assert property (
      r.state[0] == CH_XFER && !r.reqDelay[0] |=> r.state[0] == CH_WAIT)
      else $error("next request delayed with the delay bit clear");

   a_err_clear_write: assert property (
      r.sysErr && r.sysErrRead && wbReq && wb_we_i && wb_adr_i == OFS_MODE0
      && wb_sel_i[2] && !wb_dat_i[BIT_SYS_ERR] && !addrErr && !nmiReq |=> !r.sysErr)
      else $error("system error flag not cleared after read and write");
endmodule : dmc_mode_ctrl

// *** dmc_periph_model.sv ***
// Model of one requesting peripheral on a channel's request pin.
// Assumes the bench starts it with a request count; the pin idles high.
`timescale 1ns/1ps
module dmc_periph_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Commands from the bench
   input wire logic start,
   input wire logic pulseMode,
   input wire logic [7:0] reqNum,
   input wire logic [3:0] gap,
   // Request pin, active low
   output logic reqPinB
);
   logic [7:0] left;
   logic [4:0] tick;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         left <= 8'h00;
         tick <= 5'h00;
         reqPinB <= 1'b1;
      end else if (start) begin
         left <= reqNum;
         tick <= 5'h00;
         reqPinB <= 1'b1;
      end else if (!pulseMode) begin
         // level request held while any remain
         reqPinB <= (left == 8'h00);
      end else if (left != 8'h00) begin
         // Low for two cycles, then a slow or quick gap
         reqPinB <= (tick >= 5'h02);
         tick <= (tick == 5'(gap) + 5'h02) ? 5'h00 : tick + 5'h01;
         if (tick == 5'(gap) + 5'h02) begin
            left <= left - 8'h01;
         end
      end else begin
         reqPinB <= 1'b1;
      end
   end
endmodule : dmc_periph_model

// *** tb_dmc_mode_ctrl.sv ***
// Self-checking bench of the mode control block.
// Assumes a request model per channel and a classic Wishbone master.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errCount++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_dmc_mode_ctrl
   import dmc_pkg::*;
;
   logic clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq;
   logic [ADDR_W-1:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o, md, q, wd;
   logic addrErr = 0, nmiReq = 0, dual, pmPulse = 0;
   logic [NCH-1:0] transferRequestPinB, transferAckPinB, transferAckPinOe;
   logic [NCH-1:0] transferEndPinB, transferEndPinOe, pmStart = 0;
   logic [7:0] pmNum = 0;
   logic [3:0] pmGap = 4'h4;
   int errCount = 0, checked = 0, seed = 83705, cycle = 0, c, n, k, a0, e0;
   int ackCnt[NCH] = '{default: 0}, endCnt[NCH] = '{default: 0};
   int lastAck[NCH] = '{default: 0}, minGap[NCH] = '{default: 1000};

   dmc_mode_ctrl dmc_mode_ctrl_i (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .addrErr, .nmiReq, .transferRequestPinB,
      .transferAckPinB, .transferAckPinOe, .transferEndPinB, .transferEndPinOe, .irq);
   dmc_periph_model dmc_periph_model_i[NCH-1:0] (.clk, .rst_b, .start(pmStart),
      .pulseMode(pmPulse), .reqNum(pmNum), .gap(pmGap), .reqPinB(transferRequestPinB));

   always #10 clk = ~clk;

   // Pin monitor with pull-ups on undriven pins; timeout
   always @(posedge clk) begin
      cycle <= cycle + 1;
      if (cycle == 20000) begin
         errCount++;
         give_verdict();
      end
      for (int i = 0; i < NCH; i++) begin
         if (transferAckPinOe[i] && transferAckPinB[i] === 1'b0) begin
            ackCnt[i] <= ackCnt[i] + 1;
            if (cycle - lastAck[i] < minGap[i]) minGap[i] <= cycle - lastAck[i];
            lastAck[i] <= cycle;
         end
         if (transferEndPinOe[i] && transferEndPinB[i] === 1'b0) endCnt[i] <= endCnt[i] + 1;
      end
   end

   task automatic wb(input logic we, input int a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= ADDR_W'(a);
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      // Ends on the acknowledge; only the bench timeout ends a hung wait
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask : wb

   function automatic int exp_acks(input logic [31:0] m, input logic du, input int cnt);
      return (m[BIT_ACK_DIS] || du) ? 0 : cnt;
   endfunction : exp_acks

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      wb(1, 'h01, 32'hFFFF_FFFF);
      wb(1, 'h30, 32'hFFFF_FFFF);
      for (int a = 0; a <= 'h30; a += 4) begin
         wb(0, a, 0);
         `CHK("reset", 32'h0, q)
      end
      for (int t = 0; t < 8; t++) begin
         c = $random(seed) & 3;
         // reserved bit 28 left at zero
         wd = $random(seed) & 32'h6FFF_FFFF;
         wb(1, OFS_MODE0 + 4 * c, wd);
         wb(0, OFS_MODE0 + 4 * c, 0);
         `CHK("fields", wd & 32'h6C00_0000, q)
      end
      for (int t = 0; t < 10; t++) begin
         c = $random(seed) & 3;
         n = t < 2 ? 4 : ($random(seed) & 3) + 1;
         md = t < 2 ? 32'(t) << BIT_DELAY : $random(seed) & 32'h6C00_0000;
         dual = t < 2 ? 1'b0 : 1'($random(seed));
         a0 = ackCnt[c];
         e0 = endCnt[c];
         minGap[c] = 1000;
         wb(1, OFS_CTRL, 32'(dual) << c);
         wb(1, OFS_COUNT0 + 4 * c, n);
         wb(1, OFS_IRQ_MASK, 32'h1F);
         wb(1, OFS_MODE0 + 4 * c, md | 32'h8000_0000);
         pmPulse <= md[BIT_SENSE];
         pmNum <= 8'(n);
         pmGap <= 4'h4 + 4'($random(seed) & 7);
         pmStart[c] <= 1'b1;
         @(posedge clk);
         pmStart <= '0;
         k = 0;
         do begin
            wb(0, OFS_MODE0 + 4 * c, 0);
            k++;
         end while (q[BIT_XFER_EN] && k < 300);
         `CHK("modeDone", md, q)
         `CHK("ends", md[BIT_END_DIS] ? 0 : 1, endCnt[c] - e0)
         `CHK("endOe", !md[BIT_END_DIS], transferEndPinOe[c])
         if (dual) `CHK("dualAcks", 0, ackCnt[c] - a0)
         else `CHK("acks", exp_acks(md, dual, n), ackCnt[c] - a0)
         if (!dual) `CHK("ackOe", !md[BIT_ACK_DIS], transferAckPinOe[c])
         if (!md[BIT_SENSE] && !md[BIT_ACK_DIS] && !dual && n > 1)
            `CHK("gap", 2 + int'(md[BIT_DELAY]), minGap[c])
         `CHK("irqSet", 1'b1, irq)
         wb(1, OFS_IRQ_MASK, 0);
         `CHK("irqMask", 1'b0, irq)
         wb(1, OFS_IRQ_MASK, 32'h1F);
         wb(1, OFS_IRQ_STAT, 32'h1 << c);
         `CHK("irqClr", 1'b0, irq)
         pmNum <= 8'h00;
         pmStart[c] <= 1'b1;
         @(posedge clk);
         pmStart <= '0;
      end
      pmPulse <= 1'b0;
      pmNum <= 8'h01;
      pmStart[3] <= 1'b1;
      @(posedge clk);
      pmStart <= '0;
      wb(1, OFS_CTRL, 0);
      wb(1, OFS_COUNT0 + 12, 2);
      wb(1, OFS_MODE0 + 12, 32'h8800_0000);
      repeat (30) @(posedge clk);
      wb(0, OFS_COUNT0 + 12, 0);
      `CHK("edgeFirst", 32'h1, q)
      wb(1, OFS_COUNT0, 3);
      wb(1, OFS_MODE0, 32'h8000_0000);
      addrErr <= 1'b1;
      @(posedge clk);
      addrErr <= 1'b0;
      wb(1, OFS_MODE0 + 4, 32'h8000_0000);
      wb(1, OFS_MODE0, 0);
      wb(0, OFS_MODE0, 0);
      `CHK("errSet", 32'h0008_0000, q)
      `CHK("errIrq", 1'b1, irq)
      wb(0, OFS_MODE0 + 4, 0);
      `CHK("lock", 32'h0, q)
      wb(1, OFS_MODE0, 0);
      wb(0, OFS_MODE0, 0);
      `CHK("errClr", 32'h0, q)
      wb(1, OFS_IRQ_STAT, 32'h10);
      wb(1, OFS_CTRL, 32'h10);
      nmiReq <= 1'b1;
      @(posedge clk);
      nmiReq <= 1'b0;
      wb(0, OFS_MODE0, 0);
      `CHK("stopErr", 32'h0, q)
      give_verdict();
   end
endmodule : tb_dmc_mode_ctrl
